// ---- gpp_top.sv ----
// gas reading filtering, compensation, scaling and heater control
`timescale 1ns/1ps
module gpp_top
  import gpp_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_sensor_reset,
  input wire logic i_raw_valid,
  input wire logic [15:0] i_raw_conc,
  input wire logic signed [15:0] i_temperature,
  input wire logic i_wr_req,
  input wire logic [15:0] i_wr_addr,
  input wire logic [15:0] i_wr_data,
  input wire logic i_rd_req,
  input wire logic i_rd_holding,
  input wire logic [15:0] i_rd_addr,
  output logic o_rd_valid,
  output gpp_word_t o_rd_data,
  output logic o_rd_err,
  output logic o_wr_err,
  output logic o_meas_update,
  output logic o_busy,
  output logic o_heater_on
);

  // configuration group
  logic [15:0] control_reg, control_next;
  logic [15:0] setpoint_reg, setpoint_next;
  logic [15:0] pressure_reg, pressure_next;
  logic [15:0] num_reg, num_next;
  logic [15:0] den_reg, den_next;
  logic [15:0] num_pend_reg, num_pend_next;
  logic num_pend_ok_reg, num_pend_ok_next;
  logic wr_err_reg, wr_err_next;
  gpp_cfg_t cfg;

  // processing group
  gpp_state_t state_reg, state_next;
  logic [15:0] raw_reg, raw_next;
  logic [15:0] filt_reg, filt_next;
  logic primed_reg, primed_next;
  logic [15:0] fcomp_reg, fcomp_next;
  logic [15:0] ucomp_reg, ucomp_next;
  gpp_results_t res_reg, res_next;
  logic update_reg, update_next;
  logic busy_reg, busy_next;
  logic signed [16:0] diff;
  logic [15:0] diff_mag;
  logic [3:0] shift;
  logic signed [16:0] step;
  logic [31:0] scale_prod;
  logic [31:0] scale_quot;
  logic [15:0] fcomp_w, ucomp_w;

  // read port and heater group
  logic rd_valid_reg, rd_valid_next;
  gpp_word_t rd_data_reg, rd_data_next;
  logic rd_err_reg, rd_err_next;
  logic heater_reg, heater_next;

  function automatic logic [15:0] sat16(input logic [31:0] v);
    sat16 = (v > {16'h0000, SAT_MAX}) ? SAT_MAX : v[15:0];
  endfunction

  function automatic gpp_word_t to_word(input logic [15:0] v);
    to_word.msb = v[15:8];
    to_word.lsb = v[7:0];
  endfunction

  always_comb
  begin
    cfg.static_en = control_reg[CTL_STATIC_BIT];
    cfg.dynamic_en = control_reg[CTL_DYNAMIC_BIT] & control_reg[CTL_STATIC_BIT];
    cfg.pcomp_en = control_reg[CTL_PCOMP_BIT];
    cfg.heater_en = control_reg[CTL_HEATER_BIT];
  end

  // host writes to holding registers
  always_comb
  begin
    control_next = control_reg;
    setpoint_next = setpoint_reg;
    pressure_next = pressure_reg;
    num_next = num_reg;
    den_next = den_reg;
    num_pend_next = num_pend_reg;
    num_pend_ok_next = num_pend_ok_reg;
    wr_err_next = 1'b0;
    if (i_wr_req)
    begin
      case (i_wr_addr)
        HR_SCALE_NUM:
        begin
          num_pend_next = i_wr_data;
          num_pend_ok_next = 1'b1;
        end
        HR_SCALE_DEN:
        begin
          if (num_pend_ok_reg)
          begin
            num_next = num_pend_reg;
            den_next = i_wr_data;
          end
          else
          begin
            wr_err_next = 1'b1;
          end
          num_pend_ok_next = 1'b0;
        end
        HR_AIR_PRESSURE: pressure_next = i_wr_data;
        HR_CONTROL: control_next = {12'h000, i_wr_data[3:0]};
        HR_HEATER_SETPOINT: setpoint_next = i_wr_data;
        default: wr_err_next = 1'b1;
      endcase
    end
    // sensor reset drops a staged numerator
    if (i_sensor_reset)
    begin
      num_pend_ok_next = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      control_reg <= CONTROL_RESET;
      setpoint_reg <= SETPOINT_RESET;
      pressure_reg <= PRESSURE_RESET;
      num_reg <= SCALE_NUM_RESET;
      den_reg <= SCALE_DEN_RESET;
      num_pend_reg <= SCALE_NUM_RESET;
      num_pend_ok_reg <= 1'b0;
      wr_err_reg <= 1'b0;
    end
    else
    begin
      control_reg <= control_next;
      setpoint_reg <= setpoint_next;
      pressure_reg <= pressure_next;
      num_reg <= num_next;
      den_reg <= den_next;
      num_pend_reg <= num_pend_next;
      num_pend_ok_reg <= num_pend_ok_next;
      wr_err_reg <= wr_err_next;
    end
  end

  gpp_press_comp u_comp_filt (
    .i_conc(filt_reg),
    .i_pressure(pressure_reg),
    .i_enable(cfg.pcomp_en),
    .o_conc(fcomp_w)
  );

  gpp_press_comp u_comp_unfilt (
    .i_conc(raw_reg),
    .i_pressure(pressure_reg),
    .i_enable(cfg.pcomp_en),
    .o_conc(ucomp_w)
  );

  // measurement pipeline
  always_comb
  begin
    state_next = state_reg;
    raw_next = raw_reg;
    filt_next = filt_reg;
    primed_next = primed_reg;
    fcomp_next = fcomp_reg;
    ucomp_next = ucomp_reg;
    res_next = res_reg;
    update_next = 1'b0;
    diff = $signed({1'b0, raw_reg}) - $signed({1'b0, filt_reg});
    diff_mag = diff[16] ? 16'(-diff) : diff[15:0];
    shift = (cfg.dynamic_en && diff_mag > DYN_STEP_THRESH)
      ? DYNAMIC_SHIFT : STATIC_SHIFT;
    step = diff >>> shift;
    scale_prod = fcomp_reg * num_reg;
    scale_quot = (den_reg == 16'h0000) ? {16'h0000, SAT_MAX}
      : scale_prod / {16'h0000, den_reg};
    case (state_reg)
      GPP_IDLE:
      begin
        if (i_raw_valid)
        begin
          raw_next = i_raw_conc;
          state_next = GPP_FILTER;
        end
      end
      GPP_FILTER:
      begin
        if (!cfg.static_en || !primed_reg)
        begin
          filt_next = raw_reg;
        end
        else
        begin
          filt_next = 16'($signed({1'b0, filt_reg}) + step);
        end
        primed_next = 1'b1;
        state_next = GPP_COMPENSATE;
      end
      GPP_COMPENSATE:
      begin
        fcomp_next = fcomp_w;
        ucomp_next = ucomp_w;
        state_next = GPP_SCALE;
      end
      GPP_SCALE:
      begin
        res_next.filt_comp = fcomp_reg;
        res_next.unfilt_comp = ucomp_reg;
        res_next.filt_only = filt_reg;
        res_next.unfilt_raw = raw_reg;
        res_next.scaled = sat16(scale_quot);
        update_next = 1'b1;
        state_next = GPP_IDLE;
      end
      default: state_next = GPP_IDLE;
    endcase
    busy_next = (state_next != GPP_IDLE);
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset || i_sensor_reset)
    begin
      state_reg <= GPP_IDLE;
      raw_reg <= 16'h0000;
      filt_reg <= 16'h0000;
      primed_reg <= 1'b0;
      fcomp_reg <= 16'h0000;
      ucomp_reg <= 16'h0000;
      res_reg <= '0;
      update_reg <= 1'b0;
      busy_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      raw_reg <= raw_next;
      filt_reg <= filt_next;
      primed_reg <= primed_next;
      fcomp_reg <= fcomp_next;
      ucomp_reg <= ucomp_next;
      res_reg <= res_next;
      update_reg <= update_next;
      busy_reg <= busy_next;
    end
  end

  // register reads and heater
  always_comb
  begin
    rd_valid_next = i_rd_req;
    rd_err_next = 1'b0;
    rd_data_next = to_word(16'h0000);
    if (i_rd_req && !i_rd_holding)
    begin
      case (i_rd_addr)
        IR_FILT_COMP: rd_data_next = to_word(res_reg.filt_comp);
        IR_UNFILT_COMP: rd_data_next = to_word(res_reg.unfilt_comp);
        IR_FILT_ONLY: rd_data_next = to_word(res_reg.filt_only);
        IR_UNFILT_RAW: rd_data_next = to_word(res_reg.unfilt_raw);
        IR_SCALED: rd_data_next = to_word(res_reg.scaled);
        default: rd_err_next = 1'b1;
      endcase
    end
    else if (i_rd_req)
    begin
      case (i_rd_addr)
        HR_SCALE_NUM: rd_data_next = to_word(num_reg);
        HR_SCALE_DEN: rd_data_next = to_word(den_reg);
        HR_AIR_PRESSURE: rd_data_next = to_word(pressure_reg);
        HR_CONTROL: rd_data_next = to_word(control_reg);
        HR_HEATER_SETPOINT: rd_data_next = to_word(setpoint_reg);
        default: rd_err_next = 1'b1;
      endcase
    end
    heater_next = cfg.heater_en && (i_temperature < $signed(setpoint_reg));
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      rd_valid_reg <= 1'b0;
      rd_data_reg <= '0;
      rd_err_reg <= 1'b0;
      heater_reg <= 1'b0;
    end
    else
    begin
      rd_valid_reg <= rd_valid_next;
      rd_data_reg <= rd_data_next;
      rd_err_reg <= rd_err_next;
      heater_reg <= heater_next;
    end
  end

  assign o_rd_valid = rd_valid_reg;
  assign o_rd_data = rd_data_reg;
  assign o_rd_err = rd_err_reg;
  assign o_wr_err = wr_err_reg;
  assign o_meas_update = update_reg;
  assign o_busy = busy_reg;
  assign o_heater_on = heater_reg;

endmodule

// ---- gpp_pkg.sv ----
// constants, types and register map for gas reading post-processing
// Contract
// - heater switches on when temperature is below a host-settable setpoint
// - host can disable heaters entirely; then no heater activation at all
// - static filter adds a fixed fraction of the raw-minus-filtered difference
// - on a real concentration step the dynamic stage enlarges that fraction
// - filtered and unfiltered values computed side by side, always readable
// - static and dynamic filter stages enabled after factory configuration
// - compensation corrects one percent per kPa off 101.325 kPa reference
// - pressure compensation off from factory, on only when host enables it
// - host writes air pressure register; latest value feeds compensation
// - four result registers: filt+comp, unfilt+comp, unfilt, filt only
// - compensation off: compensated registers equal uncompensated partners
// - scaled register is filtered compensated value times numerator/denominator
// - scaled register counts 0.01 percent LFL; unscaled one counts ppm
// - scale pair survives a sensor reset and reads back at same addresses
package gpp_pkg;

  // input register addresses (zero based)
  localparam logic [15:0] IR_FILT_COMP = 16'h0003;
  localparam logic [15:0] IR_UNFILT_COMP = 16'h0008;
  localparam logic [15:0] IR_FILT_ONLY = 16'h0009;
  localparam logic [15:0] IR_UNFILT_RAW = 16'h000A;
  localparam logic [15:0] IR_SCALED = 16'h000D;

  // holding register addresses
  localparam logic [15:0] HR_SCALE_NUM = 16'h0014;
  localparam logic [15:0] HR_SCALE_DEN = 16'h0015;
  localparam logic [15:0] HR_AIR_PRESSURE = 16'h002E;
  localparam logic [15:0] HR_CONTROL = 16'h0030;
  localparam logic [15:0] HR_HEATER_SETPOINT = 16'h0031;

  // control register field positions
  localparam int CTL_STATIC_BIT = 0;
  localparam int CTL_DYNAMIC_BIT = 1;
  localparam int CTL_PCOMP_BIT = 2;
  localparam int CTL_HEATER_BIT = 3;

  // factory values after reset
  localparam logic [15:0] CONTROL_RESET = 16'h000B;
  localparam logic [15:0] SETPOINT_RESET = 16'h0000;
  localparam logic [15:0] PRESSURE_RESET = 16'h2794;
  localparam logic [15:0] SCALE_NUM_RESET = 16'h0001;
  localparam logic [15:0] SCALE_DEN_RESET = 16'h0001;

  // filter fractions as right shifts, and the step detector threshold
  localparam logic [3:0] STATIC_SHIFT = 4'h3;
  localparam logic [3:0] DYNAMIC_SHIFT = 4'h1;
  localparam logic [15:0] DYN_STEP_THRESH = 16'h0064;

  // pressure register counts 10 Pa; reference 101.325 kPa in Pa
  localparam logic [19:0] PA_PER_COUNT = 20'h0000A;
  localparam logic [20:0] REF_PRESSURE_PA = 21'h018BCD;
  // round(2^32 / 100000): one percent per 1000 Pa
  localparam logic [15:0] PCT_PER_KPA_RECIP = 16'hA7C6;
  localparam int RECIP_FRAC_BITS = 32;

  localparam logic [15:0] SAT_MAX = 16'hFFFF;

  typedef struct packed {
    logic [7:0] msb;
    logic [7:0] lsb;
  } gpp_word_t;

  typedef struct packed {
    logic static_en;
    logic dynamic_en;
    logic pcomp_en;
    logic heater_en;
  } gpp_cfg_t;

  typedef struct packed {
    logic [15:0] filt_comp;
    logic [15:0] unfilt_comp;
    logic [15:0] filt_only;
    logic [15:0] unfilt_raw;
    logic [15:0] scaled;
  } gpp_results_t;

  typedef enum logic [1:0] {
    GPP_IDLE,
    GPP_FILTER,
    GPP_COMPENSATE,
    GPP_SCALE
  } gpp_state_t;

endpackage

// ---- gpp_press_comp.sv ----
// pressure compensation of one concentration value
`timescale 1ns/1ps
module gpp_press_comp
  import gpp_pkg::*;
(
  input wire logic [15:0] i_conc,
  input wire logic [15:0] i_pressure,
  input wire logic i_enable,
  output logic [15:0] o_conc
);

  logic [19:0] press_pa;
  logic signed [20:0] dev_pa;
  logic signed [37:0] prod;
  logic signed [54:0] scaled;
  logic signed [22:0] corr;
  logic signed [23:0] result;

  always_comb
  begin
    press_pa = 20'(i_pressure * PA_PER_COUNT);
    dev_pa = $signed({1'b0, press_pa}) - $signed(REF_PRESSURE_PA);
    prod = $signed({1'b0, i_conc}) * dev_pa;
    scaled = 55'(prod * $signed({1'b0, PCT_PER_KPA_RECIP}));
    corr = scaled[54:RECIP_FRAC_BITS];
    result = $signed({8'h00, i_conc}) - $signed({corr[22], corr});
    if (!i_enable)
    begin
      o_conc = i_conc;
    end
    else if (result < 0)
    begin
      o_conc = 16'h0000;
    end
    else if (result > $signed({8'h00, SAT_MAX}))
    begin
      o_conc = SAT_MAX;
    end
    else
    begin
      o_conc = result[15:0];
    end
  end

endmodule

// ---- gpp_checker.sv ----
// concurrent checks on the post-processing block ports
`timescale 1ns/1ps
module gpp_checker
  import gpp_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_sensor_reset,
  input wire logic i_raw_valid,
  input wire logic [15:0] i_raw_conc,
  input wire logic signed [15:0] i_temperature,
  input wire logic i_wr_req,
  input wire logic [15:0] i_wr_addr,
  input wire logic [15:0] i_wr_data,
  input wire logic i_rd_req,
  input wire logic i_rd_holding,
  input wire logic [15:0] i_rd_addr,
  input wire logic o_rd_valid,
  input wire gpp_word_t o_rd_data,
  input wire logic o_rd_err,
  input wire logic o_wr_err,
  input wire logic o_meas_update,
  input wire logic o_busy,
  input wire logic o_heater_on
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);

  read_answer_a: assert property (i_rd_req |=> o_rd_valid)
    else $error("read not answered in one cycle");
  read_quiet_a: assert property (!i_rd_req |=> !o_rd_valid)
    else $error("read answer without request");
  err_data_zero_a: assert property (o_rd_err |-> o_rd_valid && o_rd_data == 16'h0000)
    else $error("refused read carries data");
  space_refused_a: assert property (i_rd_req && i_rd_holding &&
    i_rd_addr == IR_FILT_COMP |=> o_rd_err)
    else $error("input address accepted in holding space");
  scaled_mapped_a: assert property (i_rd_req && !i_rd_holding &&
    i_rd_addr == IR_SCALED |=> !o_rd_err)
    else $error("scaled register read refused");
  update_latency_a: assert property (disable iff (i_reset || i_sensor_reset)
    i_raw_valid && !o_busy |-> ##4 o_meas_update)
    else $error("result update not four cycles after sample");
  busy_span_a: assert property (disable iff (i_reset || i_sensor_reset)
    $rose(o_busy) |-> o_busy [*3] ##1 !o_busy)
    else $error("busy span not three cycles");
  update_pulse_a: assert property (o_meas_update |-> $past(o_busy) ##1 !o_meas_update)
    else $error("update pulse malformed");
  wr_err_cause_a: assert property (o_wr_err |-> $past(i_wr_req))
    else $error("write error without write");
  heater_steady_a: assert property ($stable(i_temperature) &&
    $past(i_temperature) == $past(i_temperature, 2) && !$past(i_wr_req) &&
    !$past(i_wr_req, 2) && !$past(i_reset) && !$past(i_reset, 2)
    |-> $stable(o_heater_on))
    else $error("heater changed with no cause");
endmodule

// ---- gpp_host_model.sv ----
// host side model issuing holding writes and register reads
`timescale 1ns/1ps
module gpp_host_model
  import gpp_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rd_valid,
  input wire gpp_word_t i_rd_data,
  input wire logic i_rd_err,
  input wire logic i_wr_err,
  output logic o_wr_req,
  output logic [15:0] o_wr_addr,
  output logic [15:0] o_wr_data,
  output logic o_rd_req,
  output logic o_rd_holding,
  output logic [15:0] o_rd_addr
);
  initial
  begin
    o_wr_req = 1'b0;
    o_wr_addr = 16'h0000;
    o_wr_data = 16'h0000;
    o_rd_req = 1'b0;
    o_rd_holding = 1'b0;
    o_rd_addr = 16'h0000;
  end

  // released lines show inverted values
  task automatic wr(input logic [15:0] addr, input logic [15:0] data,
                    output logic err);
    @(negedge i_clk_sys);
    o_wr_req = 1'b1;
    o_wr_addr = addr;
    o_wr_data = data;
    @(negedge i_clk_sys);
    o_wr_req = 1'b0;
    o_wr_addr = ~addr;
    o_wr_data = ~data;
    err = i_wr_err;
  endtask

  task automatic rd(input logic hold, input logic [15:0] addr,
                    output logic [15:0] data, output logic err);
    @(negedge i_clk_sys);
    o_rd_req = 1'b1;
    o_rd_holding = hold;
    o_rd_addr = addr;
    @(negedge i_clk_sys);
    o_rd_req = 1'b0;
    o_rd_holding = ~hold;
    o_rd_addr = ~addr;
    data = (i_rd_valid === 1'b1) ? i_rd_data : 'x;
    err = i_rd_err;
  endtask

  // numerator then denominator as one pair
  task automatic wr_scale(input logic [15:0] num, input logic [15:0] den);
    logic e;
    wr(HR_SCALE_NUM, num, e);
    wr(HR_SCALE_DEN, den, e);
  endtask
endmodule

// ---- tb.sv ----
// self-checking testbench for gas reading post-processing
`timescale 1ns/1ps
module tb;
  import gpp_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_reset = 1'b1;
  logic i_sensor_reset = 1'b0;
  logic i_raw_valid = 1'b0;
  logic [15:0] i_raw_conc = 16'h0000;
  logic signed [15:0] i_temperature = 16'sh0005;
  logic i_wr_req, i_rd_req, i_rd_holding;
  logic [15:0] i_wr_addr, i_wr_data, i_rd_addr;
  logic o_rd_valid, o_rd_err, o_wr_err, o_meas_update, o_busy, o_heater_on;
  gpp_word_t o_rd_data;
  int err_count = 0;
  int checked = 0;
  logic [15:0] rdat;
  logic rerr;

  always #5 i_clk_sys = ~i_clk_sys;

  gpp_host_model i_gpp_host_model (.i_clk_sys(i_clk_sys),
    .i_rd_valid(o_rd_valid), .i_rd_data(o_rd_data), .i_rd_err(o_rd_err),
    .i_wr_err(o_wr_err), .o_wr_req(i_wr_req), .o_wr_addr(i_wr_addr),
    .o_wr_data(i_wr_data), .o_rd_req(i_rd_req), .o_rd_holding(i_rd_holding),
    .o_rd_addr(i_rd_addr));

  gpp_top i_gpp_top (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
    .i_sensor_reset(i_sensor_reset), .i_raw_valid(i_raw_valid),
    .i_raw_conc(i_raw_conc), .i_temperature(i_temperature),
    .i_wr_req(i_wr_req), .i_wr_addr(i_wr_addr), .i_wr_data(i_wr_data),
    .i_rd_req(i_rd_req), .i_rd_holding(i_rd_holding), .i_rd_addr(i_rd_addr),
    .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .o_rd_err(o_rd_err),
    .o_wr_err(o_wr_err), .o_meas_update(o_meas_update), .o_busy(o_busy),
    .o_heater_on(o_heater_on));

  task automatic conclude();
    if (err_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] exp,
                     input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic rdc(input logic hold, input logic [15:0] addr,
                     input logic [15:0] exp, input logic exp_err);
    i_gpp_host_model.rd(hold, addr, rdat, rerr);
    chk($sformatf("read %h", addr), exp, rdat);
    chk($sformatf("read error %h", addr), {15'h0000, exp_err}, {15'h0000, rerr});
  endtask

  task automatic wrc(input logic [15:0] addr, input logic [15:0] data,
                     input logic exp_err);
    i_gpp_host_model.wr(addr, data, rerr);
    chk($sformatf("write error %h", addr), {15'h0000, exp_err}, {15'h0000, rerr});
  endtask

  task automatic smp(input logic [15:0] raw, input logic [15:0] fc,
    input logic [15:0] uc, input logic [15:0] fo, input logic [15:0] ur,
    input logic [15:0] sc);
    int n;
    @(negedge i_clk_sys);
    i_raw_valid = 1'b1;
    i_raw_conc = raw;
    @(negedge i_clk_sys);
    i_raw_valid = 1'b0;
    i_raw_conc = ~raw;
    n = 0;
    while (o_meas_update !== 1'b1 && n < 8)
    begin
      @(negedge i_clk_sys);
      n++;
    end
    chk("update", 16'h0001, {15'h0000, o_meas_update});
    rdc(1'b0, IR_FILT_COMP, fc, 1'b0);
    rdc(1'b0, IR_UNFILT_COMP, uc, 1'b0);
    rdc(1'b0, IR_FILT_ONLY, fo, 1'b0);
    rdc(1'b0, IR_UNFILT_RAW, ur, 1'b0);
    rdc(1'b0, IR_SCALED, sc, 1'b0);
  endtask

  task automatic heat(input logic [15:0] temp, input logic exp);
    @(negedge i_clk_sys);
    i_temperature = temp;
    repeat (2) @(negedge i_clk_sys);
    chk("heater", {15'h0000, exp}, {15'h0000, o_heater_on});
  endtask

  initial
  begin
    repeat (20) @(negedge i_clk_sys);
    i_reset = 1'b0;
    rdc(1'b1, HR_CONTROL, 16'h000B, 1'b0);
    rdc(1'b1, HR_AIR_PRESSURE, 16'h2794, 1'b0);
    rdc(1'b1, HR_SCALE_NUM, 16'h0001, 1'b0);
    rdc(1'b0, 16'h0001, 16'h0000, 1'b1);
    rdc(1'b1, IR_FILT_COMP, 16'h0000, 1'b1);
    heat(16'h0005, 1'b0);
    heat(16'hFFFB, 1'b1);
    smp(16'h03E8, 16'h03E8, 16'h03E8, 16'h03E8, 16'h03E8, 16'h03E8);
    smp(16'h0410, 16'h03ED, 16'h0410, 16'h03ED, 16'h0410, 16'h03ED);
    smp(16'h057D, 16'h04B5, 16'h057D, 16'h04B5, 16'h057D, 16'h04B5);
    wrc(HR_CONTROL, 16'h0008, 1'b0);
    smp(16'h07D0, 16'h07D0, 16'h07D0, 16'h07D0, 16'h07D0, 16'h07D0);
    i_gpp_host_model.wr_scale(16'h22EF, 16'h1000);
    rdc(1'b1, HR_SCALE_NUM, 16'h22EF, 1'b0);
    smp(16'h1000, 16'h1000, 16'h1000, 16'h1000, 16'h1000, 16'h22EF);
    @(negedge i_clk_sys);
    i_sensor_reset = 1'b1;
    repeat (2) @(negedge i_clk_sys);
    i_sensor_reset = 1'b0;
    rdc(1'b1, HR_SCALE_NUM, 16'h22EF, 1'b0);
    rdc(1'b1, HR_SCALE_DEN, 16'h1000, 1'b0);
    wrc(HR_SCALE_DEN, 16'h0002, 1'b1);
    rdc(1'b1, HR_SCALE_DEN, 16'h1000, 1'b0);
    wrc(HR_AIR_PRESSURE, 16'h2710, 1'b0);
    wrc(HR_CONTROL, 16'h000C, 1'b0);
    smp(16'h03E8, 16'h03F6, 16'h03F6, 16'h03E8, 16'h03E8, 16'h08A5);
    wrc(HR_HEATER_SETPOINT, 16'hFFF6, 1'b0);
    heat(16'hFFFB, 1'b0);
    heat(16'hFFEC, 1'b1);
    wrc(HR_CONTROL, 16'h0004, 1'b0);
    heat(16'hFFEC, 1'b0);
    conclude();
  end

  initial
  begin
    #100000;
    err_count++;
    conclude();
  end
endmodule

bind gpp_top gpp_checker i_gpp_checker (.i_clk_sys(i_clk_sys),
  .i_reset(i_reset), .i_sensor_reset(i_sensor_reset),
  .i_raw_valid(i_raw_valid), .i_raw_conc(i_raw_conc),
  .i_temperature(i_temperature), .i_wr_req(i_wr_req), .i_wr_addr(i_wr_addr),
  .i_wr_data(i_wr_data), .i_rd_req(i_rd_req), .i_rd_holding(i_rd_holding),
  .i_rd_addr(i_rd_addr), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data),
  .o_rd_err(o_rd_err), .o_wr_err(o_wr_err), .o_meas_update(o_meas_update),
  .o_busy(o_busy), .o_heater_on(o_heater_on));
